// *** src/bt_defines.vh ***
// Register map, field positions and reset values of the baud timer
`ifndef BT_DEFINES_VH
`define BT_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define BT_IDX_SERIAL_STATUS   8'h0c
`define BT_IDX_TIMER_COUNT     8'h0e
`define BT_IDX_PULSE_PRESET    8'h0f
`define BT_IDX_TIMER_CONTROL   8'h0c
`define BT_IDX_IRQ_ENABLE      8'h0f

// Control space base, separates the indices that share a number
`define BT_CTRL_SPACE_BASE     8'h40

`define BT_ADDR_SERIAL_STATUS  8'h30
`define BT_ADDR_TIMER_COUNT    8'h38
`define BT_ADDR_PULSE_PRESET   8'h3c
`define BT_ADDR_TIMER_CONTROL  8'h70
`define BT_ADDR_IRQ_ENABLE     8'h7c

// Field positions
`define BT_CTRL_RUN_BIT        2
`define BT_MATCH_FLAG_BIT      4
`define BT_MATCH_IRQ_EN_BIT    3

// Prescale select encodings
`define BT_PRESC_DIV1          2'h0
`define BT_PRESC_DIV4          2'h1
`define BT_PRESC_DIV8          2'h2
`define BT_PRESC_DIV16         2'h3

// Fixed divide by four ahead of the prescaler
`define BT_OSC_DIV             6'h04

// Terminal prescaler state per ratio, fixed divide by four folded in
`define BT_PRESC_LAST_DIV1     6'h03
`define BT_PRESC_LAST_DIV4     6'h0f
`define BT_PRESC_LAST_DIV8     6'h1f
`define BT_PRESC_LAST_DIV16    6'h3f

// Reset values
`define BT_RST_COUNT           8'h00
`define BT_RST_PRESET          8'h00
`define BT_RST_CONTROL         3'h0
`define BT_RST_PRESC           6'h00

`endif

// *** src/bt_baud_timer.v ***
// Baud timer: 8-bit up-counter with prescaler and match output
//
// Notes on behaviour
// - Eight-bit up-counter behind a prescaler, input clock is the oscillator over four.
// - Prescaler divides by one, four, eight or sixteen only.
// - Control bits one and zero pick ratio: 00/1, 01/4, 10/8, 11/16.
// - Prescaler cleared on writes to counter or control, and on reset.
// - Counter readable and writable, cleared to zero on reset.
// - Control bit two runs the timer; zero halts it to save power.
// - Counter increments per prescaled tick until equal to preset, then returns to zero.
// - On match the output level toggles and the match flag sets together.
// - Timer output feeds the serial shift clock when selected as source.
// - Match flag lives in bit four of the serial status register.
// - Bit three of interrupt control enables the match interrupt.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "bt_defines.vh"

module bt_baud_timer (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       serial_clk_sel_timer,
    output reg        timer_out,
    output reg        serial_shift_clk,
    output wire       irq
);

    // Counter and its preset
    reg  [7:0] count_q;
    reg  [7:0] count_d;
    reg  [7:0] preset_q;
    reg  [7:0] preset_d;

    // Control: run bit and prescale select
    reg  [2:0] control_q;
    reg  [2:0] control_d;

    // Prescaler, fixed divide by four folded in
    reg  [5:0] presc_q;
    reg  [5:0] presc_d;

    // Match flag and its interrupt enable
    reg        flag_q;
    reg        flag_d;
    reg        irq_en_q;
    reg        irq_en_d;

    // Output levels and read path
    reg        timer_out_d;
    reg        shift_clk_d;
    reg  [7:0] rdata_d;
    reg  [7:0] rdata_q_d;

    // Exact byte-address match; a partial decode would alias shared indices
    function reg_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            reg_hit = (addr == target);
        end
    endfunction

    // Last prescaler state before a tick
    function [5:0] presc_last;
        input [1:0] sel;
        begin
            case (sel)
                `BT_PRESC_DIV1: begin
                    presc_last = `BT_PRESC_LAST_DIV1;
                end
                `BT_PRESC_DIV4: begin
                    presc_last = `BT_PRESC_LAST_DIV4;
                end
                `BT_PRESC_DIV8: begin
                    presc_last = `BT_PRESC_LAST_DIV8;
                end
                default: begin
                    presc_last = `BT_PRESC_LAST_DIV16;
                end
            endcase
        end
    endfunction

    // Write decodes
    wire wr_count   = reg_wr && reg_hit(reg_addr, `BT_ADDR_TIMER_COUNT);
    wire wr_preset  = reg_wr && reg_hit(reg_addr, `BT_ADDR_PULSE_PRESET);
    wire wr_control = reg_wr && reg_hit(reg_addr, `BT_ADDR_TIMER_CONTROL);
    wire wr_status  = reg_wr && reg_hit(reg_addr, `BT_ADDR_SERIAL_STATUS);
    wire wr_irq_en  = reg_wr && reg_hit(reg_addr, `BT_ADDR_IRQ_ENABLE);

    // Read decodes
    wire rd_count   = reg_hit(reg_addr, `BT_ADDR_TIMER_COUNT);
    wire rd_preset  = reg_hit(reg_addr, `BT_ADDR_PULSE_PRESET);
    wire rd_control = reg_hit(reg_addr, `BT_ADDR_TIMER_CONTROL);
    wire rd_status  = reg_hit(reg_addr, `BT_ADDR_SERIAL_STATUS);
    wire rd_irq_en  = reg_hit(reg_addr, `BT_ADDR_IRQ_ENABLE);

    wire run     = control_q[`BT_CTRL_RUN_BIT];
    wire restart = wr_count || wr_control;
    wire at_last = (presc_q == presc_last(control_q[1:0]));

    // A write that restarts the prescaler also swallows a tick due that cycle,
    // so the first tick after any such write is always a full period away
    wire tick  = run && at_last && !restart;
    wire match = tick && (count_q == preset_q);

    // Prescaler next value; a halted timer holds it so nothing toggles
    always @* begin
        presc_d = presc_q;
        if (restart) begin
            presc_d = `BT_RST_PRESC;
        end else if (tick) begin
            presc_d = `BT_RST_PRESC;
        end else if (run) begin
            presc_d = presc_q + 6'h01;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= `BT_RST_PRESC;
        end else begin
            presc_q <= presc_d;
        end
    end

    // Counter next value; a software write beats a tick in the same cycle
    always @* begin
        count_d = count_q;
        if (wr_count) begin
            count_d = reg_wdata;
        end else if (match) begin
            count_d = 8'h00;
        end else if (tick) begin
            count_d = count_q + 8'h01;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `BT_RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // Preset; software must load it before starting the timer
    always @* begin
        preset_d = preset_q;
        if (wr_preset) begin
            preset_d = reg_wdata;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            preset_q <= `BT_RST_PRESET;
        end else begin
            preset_q <= preset_d;
        end
    end

    // Control; upper bits are not stored at all
    always @* begin
        control_d = control_q;
        if (wr_control) begin
            control_d = reg_wdata[2:0];
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= `BT_RST_CONTROL;
        end else begin
            control_q <= control_d;
        end
    end

    // Interrupt enable; only the match enable bit is kept
    always @* begin
        irq_en_d = irq_en_q;
        if (wr_irq_en) begin
            irq_en_d = reg_wdata[`BT_MATCH_IRQ_EN_BIT];
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // Match flag: a match in the clearing cycle keeps it set,
    // so software can never lose an event by clearing late
    always @* begin
        flag_d = flag_q;
        if (match) begin
            flag_d = 1'b1;
        end else if (wr_status && !reg_wdata[`BT_MATCH_FLAG_BIT]) begin
            flag_d = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Output level flips on every match
    always @* begin
        timer_out_d = timer_out;
        if (match) begin
            timer_out_d = ~timer_out;
        end
    end

    // Shift clock follows the output level in the same cycle when selected
    always @* begin
        shift_clk_d = 1'b0;
        if (serial_clk_sel_timer) begin
            shift_clk_d = timer_out_d;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= timer_out_d;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_shift_clk <= 1'b0;
        end else begin
            serial_shift_clk <= shift_clk_d;
        end
    end

    assign irq = flag_q & irq_en_q;

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        if (rd_status) begin
            rdata_d = {3'h0, flag_q, 4'h0};
        end else if (rd_count) begin
            rdata_d = count_q;
        end else if (rd_preset) begin
            rdata_d = preset_q;
        end else if (rd_control) begin
            rdata_d = {5'h00, control_q};
        end else if (rd_irq_en) begin
            rdata_d = {4'h0, irq_en_q, 3'h0};
        end
    end

    // Read data stand one cycle only, zero otherwise
    always @* begin
        rdata_q_d = 8'h00;
        if (reg_rd) begin
            rdata_q_d = rdata_d;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_q_d;
        end
    end

endmodule // bt_baud_timer

// *** tb/bt_baud_timer_checker.sv ***
// Port assertions for the baud timer
`timescale 1ns/1ps
module bt_baud_timer_checker (
    input wire       ref_clk,
    input wire       rst_n,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       serial_clk_sel_timer,
    input wire       timer_out,
    input wire       serial_shift_clk,
    input wire       irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire sel    = serial_clk_sel_timer;
    wire pre_wr = reg_wr && (reg_addr == 8'h70 || reg_addr == 8'h38);
    wire en_wr  = reg_wr && reg_addr == 8'h7c;
    wire st_wr  = reg_wr && reg_addr == 8'h30;
    AST_CTRL_HI: assert property (reg_rd && reg_addr == 8'h70 |=> reg_rdata[7:3] == 5'h00)
        else $error("control upper bits set");
    AST_STATUS: assert property (reg_rd && reg_addr == 8'h30 |=> (reg_rdata & 8'hef) == 8'h00)
        else $error("status stray bits");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_TOG_GAP: assert property ($changed(timer_out) |=> $stable(timer_out) [*3])
        else $error("output toggled too soon");
    AST_PRESC_CLR: assert property (pre_wr |=> $stable(timer_out) [*3])
        else $error("prescaler not cleared");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $changed(timer_out) || $past(en_wr))
        else $error("irq rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(st_wr) || $past(en_wr))
        else $error("irq fell without cause");
    AST_SHIFT_ON: assert property (sel && $past(sel) |-> serial_shift_clk == timer_out)
        else $error("shift clock not timer");
    AST_SHIFT_OFF: assert property (!sel && !$past(sel) |-> !serial_shift_clk)
        else $error("shift clock not idle");
endmodule // bt_baud_timer_checker

bind bt_baud_timer bt_baud_timer_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clk_sel_timer(serial_clk_sel_timer), .timer_out(timer_out),
    .serial_shift_clk(serial_shift_clk), .irq(irq));

// *** tb/bt_baud_timer_tb.sv ***
// Self-checking bench for the baud timer
`timescale 1ns/1ps
module bt_baud_timer_tb;
    logic       ref_clk, rst_n, reg_wr, reg_rd, sel;
    logic [7:0] reg_addr, reg_wdata, d;
    wire  [7:0] reg_rdata;
    wire        timer_out, shift_clk, irq;
    int         error_cnt, comparisons, cyc, n;
    bt_baud_timer uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_clk_sel_timer(sel), .timer_out(timer_out), .serial_shift_clk(shift_clk),
        .irq(irq));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task chk(input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task close_out;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task t_regs;
        rd(8'h38, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h70, 8'hfb);
        rd(8'h70, 8'h03);
        wr(8'h38, 8'h5a);
        repeat (20) @(posedge ref_clk);
        rd(8'h38, 8'h5a);
    endtask
    // Toggle lands exactly two ticks after run is set with preset 1
    task t_div;
        for (int i = 0; i < 4; i++) begin
            wr(8'h70, 8'h00);
            wr(8'h38, 8'h00);
            wr(8'h3c, 8'h01);
            d = {7'h00, timer_out};
            wr(8'h70, 8'h04 | i[7:0]);
            n = 0;
            while (timer_out === d[0] && n < 300) begin
                @(posedge ref_clk);
                #1 n++;
            end
            chk(n[7:0], i == 0 ? 8'd8 : 8'(16 << i));
            chk({7'h00, shift_clk}, {7'h00, timer_out});
            rd(8'h38, 8'h00);
            rd(8'h30, 8'h10);
        end
    endtask
    task t_irq;
        wr(8'h70, 8'h00);
        wr(8'h7c, 8'h08);
        #1 chk({7'h00, irq}, 8'h01);
        wr(8'h30, 8'h10);
        #1 chk({7'h00, irq}, 8'h01);
        wr(8'h7c, 8'h00);
        #1 chk({7'h00, irq}, 8'h00);
        wr(8'h7c, 8'h08);
        wr(8'h30, 8'h00);
        #1 chk({7'h00, irq}, 8'h00);
        rd(8'h30, 8'h00);
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, sel, reg_addr, reg_wdata} = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        sel <= 1'b1;
        t_regs;
        t_div;
        t_irq;
        close_out;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out;
        end
    end
endmodule // bt_baud_timer_tb
